// ### pm_capability_register.sv
// Summary of operation
// R01 - 16-bit capability word at offset 46h, reset 7E02h; bits 15 and 8 to 6 update, rest fixed.
// R02 - bit 15 follows bit 15 of miscellaneous configuration register at F0h.
// R03 - bits 14 to 11 read 1111b: wake possible from all four states.
// R04 - bit 10 reads 1: deep idle state supported.
// R05 - bit 9 reads 1: light idle state supported.
// R06 - bits 8 to 6 read 000b when bit 15 clear, else 001b.
// R07 - bit 5 reads 0: no device-specific initialization needed.
// R08 - reserved bit 4 reads 0.
// R09 - bit 3 reads 0: wake needs no host bus clock.
// R10 - bits 2 to 0 read 010b: power spec revision code.
// R11 - configuration writes to this register are ignored.
`timescale 1ns/10ps
`default_nettype none
module pm_capability_register (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        coldStateWakeCapable,
	input  wire logic        cfgRead,
	input  wire logic        cfgWrite,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [15:0] cfgWdata,
	output logic             cfgHit,
	output logic [15:0]      cfgRdata
);
	import pm_cap_pkg::*;

	// request decode
	logic        readHit;
	logic        writeHit;
	logic        capSelected;

	// bit 15 shadow of the misc config bit
	logic        coldWake_r;
	logic        coldWake_nxt;

	// separate fields of the capability word
	logic [3:0]  wakeSourceStateMask;
	logic        deepIdleStateSupported;
	logic        lightIdleStateSupported;
	logic [2:0]  standbySupplyCurrent;
	logic        devInitNeeded;
	logic        reservedZero;
	logic        wakeNeedsHostClock;
	logic [2:0]  powerSpecRevision;

	// partial words while the read-only part is assembled
	logic [15:0] withSpecRev;
	logic [15:0] withHostClk;
	logic [15:0] withReserved;
	logic [15:0] withDevInit;
	logic [15:0] withAuxCurrent;
	logic [15:0] withLightIdle;
	logic [15:0] withDeepIdle;
	logic [15:0] fixedWord;

	// assembled word and read path
	logic [15:0] capWord;
	logic [15:0] readMask;
	logic [15:0] cfgRdata_nxt;

	// true when a configuration offset selects this register
	function automatic logic addrSelectsCap(
		input logic [7:0] addr
	);
		logic hit;

		hit = (addr == PWR_MGMT_CAPABILITIES_OFS);
		return hit;
	endfunction

	// supply current code that goes with the cold-state wake bit
	function automatic logic [2:0] auxCodeFor(
		input logic coldWake
	);
		logic [2:0] code;

		// 55 mA standby draw only while cold-state wake is offered
		case (coldWake)
			1'b1: begin
				code = AUX_55MA;
			end
			default: begin
				code = AUX_SELF_POWERED;
			end
		endcase
		return code;
	endfunction

	// drops a field of the given width into a word at bit lsb
	function automatic logic [15:0] placeField(
		input logic [15:0] word,
		input int          lsb,
		input int          width,
		input logic [15:0] value
	);
		logic [15:0] result;
		logic        inField;
		int          offset;

		// fields never overlap, so the order of calls does not matter
		result = word;
		for (int i = 0; i < 16; i++) begin
			inField = (i >= lsb) && (i < lsb + width);
			offset  = i - lsb;
			if (inField) begin
				result[i] = value[offset[3:0]];
			end
		end
		return result;
	endfunction

	// only the cold-state wake bit is taken straight from the shadow flop
	function automatic logic bitIsUpdatable(
		input int bitPos
	);
		logic upd;

		upd = (bitPos == COLD_WAKE_BIT);
		return upd;
	endfunction

	// reads and writes are both claimed, so the host never sees a missing
	// target at this offset; a write goes no further than the claim
	always_comb begin
		readHit = cfgRead && addrSelectsCap(cfgAddr); // [R01]
	end

	always_comb begin
		writeHit = cfgWrite && addrSelectsCap(cfgAddr); // [R11]
	end

	assign capSelected = readHit || writeHit;
	assign cfgHit      = capSelected; // [R11]

	// bit 15 tracks the ROM-loaded misc config bit one clock later;
	// the ROM load settles long before software reads the word
	always_comb begin
		coldWake_nxt = coldStateWakeCapable; // [R02]
	end

	// reset leaves bit 15 at the word's reset value
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			coldWake_r <= PWR_MGMT_CAPABILITIES_RST[COLD_WAKE_BIT]; // [R01]
		end else begin
			coldWake_r <= coldWake_nxt; // [R02]
		end
	end

	// one enable per power state that may raise the wake signal
	for (genvar s = 0; s < 4; s++) begin : gen_wake_state
		assign wakeSourceStateMask[s] = WAKE_SOURCE_STATE_MASK[s]; // [R03]
	end

	// second intermediate low-power state supported
	always_comb begin
		deepIdleStateSupported = 1'b1; // [R04]
	end

	// first intermediate low-power state supported
	always_comb begin
		lightIdleStateSupported = 1'b1; // [R05]
	end

	// current code follows the shadow bit so both change together
	always_comb begin
		standbySupplyCurrent = auxCodeFor(coldWake_r); // [R06]
	end

	// no special initialization needed
	always_comb begin
		devInitNeeded = 1'b0; // [R07]
	end

	// reserved bit
	always_comb begin
		reservedZero = 1'b0; // [R08]
	end

	// wake works without the host bus clock
	always_comb begin
		wakeNeedsHostClock = 1'b0; // [R09]
	end

	// revision of the power-management register layout
	always_comb begin
		powerSpecRevision = POWER_SPEC_REVISION; // [R10]
	end

	// revision code at the bottom of the word
	always_comb begin
		withSpecRev = placeField(
			16'h0000,
			SPEC_REV_LSB,
			3,
			{13'h0000, powerSpecRevision}
		); // [R10]
	end

	// host clock need
	always_comb begin
		withHostClk = placeField(
			withSpecRev,
			WAKE_CLK_BIT,
			1,
			{15'h0000, wakeNeedsHostClock}
		); // [R09]
	end

	// reserved position
	always_comb begin
		withReserved = placeField(
			withHostClk,
			RESERVED_BIT,
			1,
			{15'h0000, reservedZero}
		); // [R08]
	end

	// initialization flag
	always_comb begin
		withDevInit = placeField(
			withReserved,
			DEV_INIT_BIT,
			1,
			{15'h0000, devInitNeeded}
		); // [R07]
	end

	// standby supply current
	always_comb begin
		withAuxCurrent = placeField(
			withDevInit,
			AUX_CURRENT_LSB,
			3,
			{13'h0000, standbySupplyCurrent}
		); // [R06]
	end

	// first idle state support
	always_comb begin
		withLightIdle = placeField(
			withAuxCurrent,
			LIGHT_IDLE_BIT,
			1,
			{15'h0000, lightIdleStateSupported}
		); // [R05]
	end

	// second idle state support
	always_comb begin
		withDeepIdle = placeField(
			withLightIdle,
			DEEP_IDLE_BIT,
			1,
			{15'h0000, deepIdleStateSupported}
		); // [R04]
	end

	// wake source states complete the read-only part
	always_comb begin
		fixedWord = placeField(
			withDeepIdle,
			WAKE_MASK_LSB,
			4,
			{12'h000, wakeSourceStateMask}
		); // [R03]
	end

	// bit 15 is the only bit taken from coldWake_r directly; the rest come from fixedWord
	for (genvar b = 0; b < 16; b++) begin : gen_cap_bit
		if (bitIsUpdatable(b)) begin : gen_update
			assign capWord[b] = coldWake_r; // [R02]
		end else begin : gen_fixed
			assign capWord[b] = fixedWord[b]; // [R01]
		end
	end

	// every bit is gated by the read hit alone
	for (genvar b = 0; b < 16; b++) begin : gen_read_mask
		assign readMask[b] = readHit;
	end

	// data leaves only on a read hit, so a write cannot reach it
	for (genvar b = 0; b < 16; b++) begin : gen_read_gate
		assign cfgRdata_nxt[b] = capWord[b] & readMask[b]; // [R01]
	end

	// registered read data; zero unless the last cycle was a read hit,
	// and cfgWdata has no path into any flop of this block
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cfgRdata <= 16'h0000;
		end else begin
			cfgRdata <= cfgRdata_nxt; // [R01] [R11]
		end
	end
endmodule
`default_nettype wire

// ### pm_cap_pkg.sv
package pm_cap_pkg;
	// configuration-space location and layout of the capability word
	localparam logic [7:0]  PWR_MGMT_CAPABILITIES_OFS = 8'h46;
	localparam logic [7:0]  MISC_CONFIG_OFS           = 8'hF0;
	localparam logic [15:0] PWR_MGMT_CAPABILITIES_RST = 16'h7E02;
	localparam int COLD_WAKE_BIT       = 15;
	localparam int MISC_COLD_WAKE_BIT  = 15;
	localparam int WAKE_MASK_LSB       = 11;
	localparam int DEEP_IDLE_BIT       = 10;
	localparam int LIGHT_IDLE_BIT      = 9;
	localparam int AUX_CURRENT_LSB     = 6;
	localparam int DEV_INIT_BIT        = 5;
	localparam int RESERVED_BIT        = 4;
	localparam int WAKE_CLK_BIT        = 3;
	localparam int SPEC_REV_LSB        = 0;
	localparam logic [3:0] WAKE_SOURCE_STATE_MASK = 4'hF;
	localparam logic [2:0] AUX_SELF_POWERED       = 3'h0;
	localparam logic [2:0] AUX_55MA               = 3'h1;
	localparam logic [2:0] POWER_SPEC_REVISION    = 3'h2;
endpackage

// ### pmc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_chk
	import pm_cap_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        coldStateWakeCapable,
	input wire logic        cfgRead,
	input wire logic        cfgWrite,
	input wire logic [7:0]  cfgAddr,
	input wire logic        cfgHit,
	input wire logic [15:0] cfgRdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence capRead;
		cfgRead && (cfgAddr == PWR_MGMT_CAPABILITIES_OFS);
	endsequence

	sequence capReadAfterRun;
		cfgRead && (cfgAddr == PWR_MGMT_CAPABILITIES_OFS) && $past(rst_b);
	endsequence

	sequence capReadOnRelease;
		cfgRead && (cfgAddr == PWR_MGMT_CAPABILITIES_OFS) && !$past(rst_b);
	endsequence

	chk_fixed_fields: assert property (
		capRead |=> cfgRdata[14:0] == {8'hFC, cfgRdata[15], 6'h02}
	) else $error("capability fixed fields wrong");

	chk_other_zero: assert property (
		cfgAddr != PWR_MGMT_CAPABILITIES_OFS |=> cfgRdata == 16'h0000
	) else $error("read data not zero for other offset");

	chk_cold_follow: assert property (
		capReadAfterRun |=> cfgRdata[15] == $past(coldStateWakeCapable, 2)
	) else $error("cold wake bit does not follow input");

	chk_aux_tracks: assert property (
		capRead |=> cfgRdata[8:6] == (cfgRdata[15] ? AUX_55MA : AUX_SELF_POWERED)
	) else $error("supply current code does not match wake bit");

	chk_release_word: assert property (
		capReadOnRelease |=> cfgRdata == PWR_MGMT_CAPABILITIES_RST
	) else $error("first read after reset not the reset word");

	chk_reset_clears: assert property (
		@(posedge clk) disable iff (1'b0) !rst_b |=> cfgRdata == 16'h0000
	) else $error("read data not cleared by reset");

	chk_hit_decode: assert property (
		cfgHit == ((cfgRead || cfgWrite) && (cfgAddr == PWR_MGMT_CAPABILITIES_OFS))
	) else $error("hit does not match request decode");

	chk_write_quiet: assert property (
		cfgWrite && !cfgRead |=> cfgRdata == 16'h0000
	) else $error("write produced read data");
endmodule
bind pm_capability_register pmc_chk pmc_chk_i (
	.clk                  (clk),
	.rst_b                (rst_b),
	.coldStateWakeCapable (coldStateWakeCapable),
	.cfgRead              (cfgRead),
	.cfgWrite             (cfgWrite),
	.cfgAddr              (cfgAddr),
	.cfgHit               (cfgHit),
	.cfgRdata             (cfgRdata)
);
`default_nettype wire

// ### pm_capability_register_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pm_capability_register_tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        coldWake = 1'b0;
	logic        cfgRead = 1'b0;
	logic        cfgWrite = 1'b0;
	logic [7:0]  cfgAddr = 8'h00;
	logic [15:0] cfgWdata = 16'h0000;
	logic        cfgHit;
	logic [15:0] cfgRdata;
	int          failures = 0;
	int          checks = 0;

	pm_capability_register pm_capability_register_i (
		.clk                  (clk),
		.rst_b                (rst_b),
		.coldStateWakeCapable (coldWake),
		.cfgRead              (cfgRead),
		.cfgWrite             (cfgWrite),
		.cfgAddr              (cfgAddr),
		.cfgWdata             (cfgWdata),
		.cfgHit               (cfgHit),
		.cfgRdata             (cfgRdata)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic compare(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// hit is checked while the request stands, data one edge later
	task automatic readWord(input logic [7:0] addr, input logic expHit, input logic [15:0] exp);
		@(posedge clk);
		cfgRead  <= 1'b1;
		cfgWrite <= 1'b0;
		cfgAddr  <= addr;
		#1;
		compare({15'h0000, cfgHit}, {15'h0000, expHit});
		@(posedge clk);
		cfgRead <= 1'b0;
		#1;
		compare(cfgRdata, exp);
		$display("read at %h done", addr);
	endtask

	task automatic writeWord(input logic [7:0] addr, input logic [15:0] data, input logic expHit);
		@(posedge clk);
		cfgWrite <= 1'b1;
		cfgRead  <= 1'b0;
		cfgAddr  <= addr;
		cfgWdata <= data;
		#1;
		compare({15'h0000, cfgHit}, {15'h0000, expHit});
		@(posedge clk);
		cfgWrite <= 1'b0;
		#1;
		compare(cfgRdata, 16'h0000);
		$display("write at %h done", addr);
	endtask

	task automatic setColdWake(input logic value);
		@(posedge clk);
		coldWake <= value;
	endtask

	task automatic wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		readWord(8'h46, 1'b1, 16'h7E02);
		writeWord(8'h46, 16'hFFFF, 1'b1);
		readWord(8'h46, 1'b1, 16'h7E02);
		setColdWake(1'b1);
		readWord(8'h46, 1'b1, 16'hFE42);
		writeWord(8'h46, 16'h0000, 1'b1);
		readWord(8'h46, 1'b1, 16'hFE42);
		readWord(8'h48, 1'b0, 16'h0000);
		writeWord(8'h48, 16'hFFFF, 1'b0);
		setColdWake(1'b0);
		readWord(8'h46, 1'b1, 16'h7E02);
		setColdWake(1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		compare(cfgRdata, 16'h0000);
		@(posedge clk);
		rst_b   <= 1'b1;
		cfgRead <= 1'b1;
		cfgAddr <= 8'h46;
		@(posedge clk);
		cfgRead <= 1'b0;
		#1;
		compare(cfgRdata, 16'h7E02);
		$display("read on reset release done");
		readWord(8'h46, 1'b1, 16'hFE42);
		wrap_up;
	end
endmodule
`default_nettype wire
